// ### core/hti_pkg.sv
// Purpose: Shared constants for the humidity and temperature readout block.
// Assumes: Core clock of 4 ns; serial link sampled on its own clock.
// Notes: Times are typical figures; cycle counts round up.
`default_nettype none
package hti_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h44;
  localparam logic RW_READ = 1'b1;
  localparam logic [1:0] STAT_VALID = 2'h0;
  localparam logic [1:0] STAT_STALE = 2'h1;
  // Resolution field inside a 16-bit configuration word.
  localparam int RES_LSB = 10;
  localparam int RES_MSB = 11;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] RES_14 = 2'h3;
  localparam logic [15:0] CFG_RESET = 16'h0c00;
  localparam int DATA_W = 14;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real NS_PER_MS = 1.0e6;
  localparam real T_WAKE_MS = 0.10;
  localparam real T_CONV8_MS = 0.55;
  localparam real T_CONV10_MS = 1.31;
  localparam real T_CONV12_MS = 4.50;
  localparam real T_CONV14_MS = 16.90;
  localparam int WAKE_CYC = int'($ceil(T_WAKE_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CONV8_CYC = int'($ceil(T_CONV8_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CONV10_CYC = int'($ceil(T_CONV10_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CONV12_CYC = int'($ceil(T_CONV12_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CONV14_CYC = int'($ceil(T_CONV14_MS * NS_PER_MS / CLK_PERIOD_NS));

  typedef enum {C_SLEEP, C_WAKE, C_HUM, C_TEMP, C_UPDATE} hti_core_t;
  typedef enum {L_IDLE, L_ADDR, L_ACK_WAIT, L_ACK, L_SEND, L_REL, L_MACK, L_NEXT,
    L_WSTOP} hti_link_t;

  // Scales a sample taken at the given resolution onto the 14-bit range.
  function automatic logic [DATA_W-1:0] hti_scale(input logic [DATA_W-1:0] s,
      input logic [1:0] res);
    logic [DATA_W-1:0] m;
    m = 14'h3fff;
    unique case (res)
      RES_8: m = 14'h3fc0;
      RES_10: m = 14'h3ff0;
      RES_12: m = 14'h3ffc;
      RES_14: m = 14'h3fff;
    endcase
    return s & m;
  endfunction
endpackage
`default_nettype wire

// ### core/hti_sync.sv
// Purpose: Two flip-flop synchroniser for independent level bits.
// Assumes: Each bit changes alone or is only read after a slower toggle.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module hti_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // hti_sync
`default_nettype wire

// ### core/hti_readout.sv
// Purpose: Serial-bus slave front end and measurement sequencer of the sensor.
// Assumes: Link pins are oversampled on link_clk; sensor samples are on ref_clk.
// Notes: Results cross to the link by toggle with data held stable meanwhile.
// Operation
// (R01) Act only as bus slave; oversampling copes with 100 kHz and 400 kHz.
// (R02) Answer only the fixed 7-bit address; ignore all others.
// (R03) Sample data on clock rise; data changes only while clock is low.
// (R04) Master sends address then direction bit, one for read.
// (R05) Every byte is eight bits plus one acknowledge bit, low meaning ack.
// (R06) Core sleeps by default and converts only after a measure request.
// (R07) A write-direction address from the master wakes the device.
// (R08) Convert humidity, then temperature, then update output before sleeping.
// (R09) Results are scaled to 14 bits and sent most significant bit first.
// (R10) A read-direction address starts a fetch and is acknowledged.
// (R11) Keep sending bytes until the master answers not-acknowledge.
// (R12) Byte one holds status and humidity top; temperature fills bytes three, four.
// (R13) Master masks the two low bits of byte four.
// (R14) Master may stop after byte two or byte three.
// (R15) Total time is wake-up plus both conversion times.
// (R16) Master waits for completion unless it checks the status bits.
// (R17) Status 00 means the result is unread since the last measurement.
// (R18) Status 01 means the result was already fetched.
// (R19) Before the first measurement completes, fetches report stale status.
// (R20) Single master; both lines are open drain with pull-ups.
// (R21) Bits eleven to ten set each resolution: 8, 10, 12, 14 bits.
// (R22) One conversion takes 0.55, 1.31, 4.50 or 16.90 ms by resolution.
// (R23) A measure request is the write address, acknowledged, then stop.
`timescale 1ns/1ps
`default_nettype none
module hti_readout
  import hti_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int CONV8_CYCLES = CONV8_CYC,
  parameter int CONV10_CYCLES = CONV10_CYC,
  parameter int CONV12_CYCLES = CONV12_CYC,
  parameter int CONV14_CYCLES = CONV14_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] hum_cfg,
  input wire logic [15:0] temp_cfg,
  input wire logic [DATA_W-1:0] hum_sample,
  input wire logic [DATA_W-1:0] temp_sample,
  output logic core_awake,
  output logic meas_done
);
  // ---------------- Core domain ----------------
  hti_core_t cstate, next_cstate;
  logic [31:0] cnt;
  logic [1:0] hum_res_l, temp_res_l;
  logic [DATA_W-1:0] hum_word, temp_word;
  logic res_tgl;
  logic req_sync, req_seen;
  logic req_tgl;
  wire req_pulse = req_sync ^ req_seen;
  wire cnt_done = (cnt == 32'h0000_0000);

  // Conversion length for a resolution code.
  function automatic logic [31:0] conv_len(input logic [1:0] res);
    logic [31:0] n;
    n = 32'(CONV14_CYCLES - 1);
    unique case (res)
      RES_8: n = 32'(CONV8_CYCLES - 1);
      RES_10: n = 32'(CONV10_CYCLES - 1);
      RES_12: n = 32'(CONV12_CYCLES - 1);
      RES_14: n = 32'(CONV14_CYCLES - 1);
    endcase
    return n;
  endfunction

  hti_sync #(.WIDTH(1)) u_req_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(req_tgl),
    .q(req_sync)
  );

  always_comb begin
    next_cstate = cstate;
    unique case (cstate)
      // (R06) sleep until request
      C_SLEEP: if (req_pulse) next_cstate = C_WAKE;
      // (R15) wake, then conversions
      C_WAKE: if (cnt_done) next_cstate = C_HUM;
      C_HUM: if (cnt_done) next_cstate = C_TEMP;
      C_TEMP: if (cnt_done) next_cstate = C_UPDATE;
      C_UPDATE: next_cstate = C_SLEEP;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cstate <= C_SLEEP;
      req_seen <= 1'b0;
      cnt <= 32'h0000_0000;
      core_awake <= 1'b0;
      meas_done <= 1'b0;
    end else begin
      cstate <= next_cstate;
      req_seen <= req_sync;
      core_awake <= (next_cstate != C_SLEEP);
      meas_done <= (cstate == C_UPDATE);
      if (cstate == C_SLEEP && req_pulse) begin
        cnt <= 32'(WAKE_CYCLES - 1);
      // (R22) conversion durations
      end else if (cstate == C_WAKE && cnt_done) begin
        cnt <= conv_len(hum_res_l);
      end else if (cstate == C_HUM && cnt_done) begin
        cnt <= conv_len(temp_res_l);
      end else if (!cnt_done) begin
        cnt <= cnt - 32'h0000_0001;
      end
    end
  end

  // Resolutions are latched at wake-up so a change mid-cycle cannot skew timing.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hum_res_l <= CFG_RESET[RES_MSB:RES_LSB];
      temp_res_l <= CFG_RESET[RES_MSB:RES_LSB];
      hum_word <= '0;
      temp_word <= '0;
      res_tgl <= 1'b0;
    end else begin
      // (R21) resolution fields
      if (cstate == C_SLEEP && req_pulse) begin
        hum_res_l <= hum_cfg[RES_MSB:RES_LSB];
        temp_res_l <= temp_cfg[RES_MSB:RES_LSB];
      end
      // (R08) update output at end
      // (R09) scale to 14 bits
      if (cstate == C_UPDATE) begin
        hum_word <= hti_scale(hum_sample, hum_res_l);
        temp_word <= hti_scale(temp_sample, temp_res_l);
        res_tgl <= ~res_tgl;
      end
    end
  end

  // ---------------- Link domain ----------------
  hti_link_t lstate;
  logic [1:0] pin_sync;
  logic p_scl, p_sda;
  logic res_sync, res_seen;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, tx;
  logic rw;
  logic [1:0] byte_idx;
  logic [1:0] status;
  logic [DATA_W-1:0] hum_copy, temp_copy;
  logic [31:0] frame;

  // (R01) oversampled slave pins
  hti_sync #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .rst(rst),
    .d({scl_in, sda_in}),
    .q(pin_sync)
  );
  hti_sync #(.WIDTH(1)) u_res_sync (
    .clk(link_clk),
    .rst(rst),
    .d(res_tgl),
    .q(res_sync)
  );

  wire s_scl = pin_sync[1];
  wire s_sda = pin_sync[0];
  wire new_res = res_sync ^ res_seen;
  wire scl_rise = ~p_scl & s_scl;
  wire scl_fall = p_scl & ~s_scl;
  wire bus_start = p_scl & s_scl & p_sda & ~s_sda;
  wire bus_stop = p_scl & s_scl & ~p_sda & s_sda;
  wire [7:0] rx_byte = {shreg[6:0], s_sda};
  // (R12) fetch frame layout
  wire [31:0] live_frame = {status, hum_copy, temp_copy, 2'b00};
  wire [7:0] next_byte = frame[8'(31 - 8 * byte_idx) -: 8];
  wire last_bit = (bit_cnt == 3'h7);

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      p_scl <= 1'b1;
      p_sda <= 1'b1;
      res_seen <= 1'b0;
      hum_copy <= '0;
      temp_copy <= '0;
    end else begin
      p_scl <= s_scl;
      p_sda <= s_sda;
      res_seen <= res_sync;
      if (new_res) begin
        hum_copy <= hum_word;
        temp_copy <= temp_word;
      end
    end
  end

  // A fresh result wins over the fetch that marks the old one read.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      // (R19) stale before first result
      status <= STAT_STALE;
    end else if (new_res) begin
      // (R17) unread result
      status <= STAT_VALID;
    end else if (lstate == L_ACK && scl_fall && rw == RW_READ) begin
      // (R18) mark as fetched
      status <= STAT_STALE;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lstate <= L_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      byte_idx <= 2'h0;
      frame <= 32'h0000_0000;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      req_tgl <= 1'b0;
    end else if (bus_start) begin
      lstate <= L_ADDR;
      bit_cnt <= 3'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      // (R23) request ends with stop
      // (R07) write address wakes core
      if (lstate == L_WSTOP) req_tgl <= ~req_tgl;
      lstate <= L_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (lstate)
        L_IDLE: ;
        L_ADDR: if (scl_rise) begin
          // (R03) sample on clock rise
          shreg <= rx_byte;
          bit_cnt <= bit_cnt + 3'h1;
          // (R04) address and direction
          // (R02) match own address
          if (last_bit) begin
            rw <= rx_byte[0];
            lstate <= (rx_byte[7:1] == SLAVE_ADDR) ? L_ACK_WAIT : L_IDLE;
          end
        end
        // (R05) drive ack low
        L_ACK_WAIT: if (scl_fall) begin
          sda_oe <= 1'b1;
          lstate <= L_ACK;
        end
        // (R10) read address acknowledged
        L_ACK: if (scl_fall) begin
          bit_cnt <= 3'h0;
          if (rw == RW_READ) begin
            frame <= live_frame;
            tx <= live_frame[31:24];
            sda_oe <= ~live_frame[31];
            byte_idx <= 2'h1;
            lstate <= L_SEND;
          end else begin
            sda_oe <= 1'b0;
            lstate <= L_WSTOP;
          end
        end
        // (R09) most significant bit first
        L_SEND: begin
          if (scl_fall) begin
            tx <= {tx[6:0], 1'b0};
            sda_oe <= ~tx[6];
          end
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (last_bit) lstate <= L_REL;
          end
        end
        L_REL: if (scl_fall) begin
          sda_oe <= 1'b0;
          lstate <= L_MACK;
        end
        // (R11) continue until not-acknowledge
        L_MACK: if (scl_rise) lstate <= s_sda ? L_IDLE : L_NEXT;
        L_NEXT: if (scl_fall) begin
          tx <= next_byte;
          sda_oe <= ~next_byte[7];
          byte_idx <= byte_idx + 2'h1;
          bit_cnt <= 3'h0;
          lstate <= L_SEND;
        end
        // (R23) data bytes void the request
        // A stop also starts with a clock rise, so only a clock fall proves a data bit.
        L_WSTOP: if (scl_fall) lstate <= L_IDLE;
      endcase
    end
  end
endmodule // hti_readout
`default_nettype wire

// ### tb/hti_readout_checker.sv
// Purpose: Port assertions for the readout block.
// Assumes: Bus half bit far longer than three link clocks.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module hti_readout_checker #(
  parameter int WAKE_CYCLES = 20,
  parameter int CONV14_CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic core_awake,
  input wire logic meas_done
);
  int awake_cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) awake_cnt <= 0;
    else awake_cnt <= core_awake ? awake_cnt + 1 : 0;
  end
  a_open_drain: assert property (@(posedge link_clk) disable iff (rst) !sda_out)
    else $error("sda driven high");
  a_sda_hold: assert property (@(posedge link_clk) disable iff (rst)
    scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("sda moved, scl high");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sda_oe) |-> !scl_in) else $error("sda pulled, scl high");
  a_wake_idle: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(core_awake) |-> scl_in) else $error("wake inside a frame");
  a_awake_min: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(core_awake) |-> core_awake[*8]) else $error("cycle too short");
  a_awake_bound: assert property (@(posedge ref_clk) disable iff (rst)
    awake_cnt <= WAKE_CYCLES + 2 * CONV14_CYCLES + 8) else $error("cycle too long");
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    meas_done |=> !meas_done) else $error("done not a pulse");
  a_done_in_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    meas_done |-> $past(awake_cnt) > WAKE_CYCLES) else $error("done without cycle");
  a_sleep_after: assert property (@(posedge ref_clk) disable iff (rst)
    meas_done |-> ##[0:2] !core_awake) else $error("no sleep after done");
endmodule // hti_readout_checker
`default_nettype wire

// ### tb/hti_master_model.sv
// Purpose: Bus master partner on the sensor link.
// Assumes: Open-drain data line resolved with a pull-up in the bench.
// Notes: Delays are whole core cycles so calls stay aligned.
`timescale 1ns/1ps
`default_nettype none
module hti_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam time HALF = 600;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
      output logic [7:0] rx, output logic ack_out);
    logic [8:0] v;
    v = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #(HALF/2) sda_low = !v[i];
      #(HALF/2) scl = 1'b1;
      #HALF v[i] = sda;
      scl = 1'b0;
    end
    rx = v[8:1];
    ack_out = v[0];
  endtask
endmodule // hti_master_model
`default_nettype wire

// ### tb/hti_readout_tb_top.sv
// Purpose: Self-checking bench for the readout block.
// Assumes: Short conversion counts set as parameters.
// Notes: The master model drives the link.
`timescale 1ns/1ps
`default_nettype none
module hti_readout_tb_top;
  import hti_pkg::*;
  localparam int WK = 20;
  localparam int CV[4] = '{40, 60, 80, 100};
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, m_low, sda_out, sda_oe, core_awake, meas_done;
  wire logic sda = !(m_low || (sda_oe && !sda_out));
  logic [15:0] hum_cfg = CFG_RESET;
  logic [15:0] temp_cfg = CFG_RESET;
  logic [DATA_W-1:0] hum_sample = '0;
  logic [DATA_W-1:0] temp_sample = '0;
  int failures = 0;
  int check_count = 0;
  always #2 ref_clk = !ref_clk;
  always #7.5 link_clk = !link_clk;
  hti_readout #(.WAKE_CYCLES(WK), .CONV8_CYCLES(CV[0]), .CONV10_CYCLES(CV[1]),
    .CONV12_CYCLES(CV[2]), .CONV14_CYCLES(CV[3])) u_hti_readout (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .hum_cfg(hum_cfg), .temp_cfg(temp_cfg),
    .hum_sample(hum_sample), .temp_sample(temp_sample), .core_awake(core_awake),
    .meas_done(meas_done));
  hti_master_model u_hti_master_model (.scl(scl), .sda_low(m_low), .sda(sda));
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [13:0] exp_scale(input logic [13:0] s, input int r);
    logic [13:0] one;
    one = 14'h1;
    return s & ~((one << (6 - 2 * r)) - one);
  endfunction
  task automatic request(input logic [6:0] addr, output logic ack);
    logic [7:0] rx;
    @(posedge ref_clk);
    #1;
    u_hti_master_model.start();
    u_hti_master_model.xfer({addr, 1'b0}, 1'b1, rx, ack);
    u_hti_master_model.stop();
  endtask
  task automatic fetch(input int n, output logic ack, output logic [31:0] f);
    logic [7:0] rx;
    logic a;
    f = '0;
    @(posedge ref_clk);
    #1;
    u_hti_master_model.start();
    u_hti_master_model.xfer({SLAVE_ADDR, RW_READ}, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      u_hti_master_model.xfer(8'hff, i == n - 1, rx, a);
      f = {f[23:0], rx};
    end
    u_hti_master_model.stop();
  endtask
  task automatic t_early_fetch();
    logic ack;
    logic [31:0] f;
    fetch(2, ack, f);
    chk1(ack, 1'b0);
    chk32(f, {16'h0, STAT_STALE, 14'h0});
    chk1(core_awake, 1'b0);
  endtask
  task automatic t_foreign();
    logic ack;
    request(SLAVE_ADDR + 7'h1, ack);
    chk1(ack, 1'b1);
    #201;
    chk1(core_awake, 1'b0);
  endtask
  task automatic t_cancel();
    logic [7:0] rx;
    logic ack;
    @(posedge ref_clk);
    #1;
    u_hti_master_model.start();
    u_hti_master_model.xfer({SLAVE_ADDR, 1'b0}, 1'b1, rx, ack);
    chk1(ack, 1'b0);
    u_hti_master_model.xfer(8'h5a, 1'b1, rx, ack);
    chk1(ack, 1'b1);
    u_hti_master_model.stop();
    #201;
    chk1(core_awake, 1'b0);
  endtask
  task automatic t_measure(input int hr, input int tr, input logic [13:0] hs,
      input logic [13:0] ts);
    logic ack;
    logic [31:0] f;
    logic [31:0] x;
    int n;
    int e;
    @(posedge ref_clk);
    #1;
    hum_cfg[RES_MSB:RES_LSB] = 2'(hr);
    temp_cfg[RES_MSB:RES_LSB] = 2'(tr);
    hum_sample = hs;
    temp_sample = ts;
    // The cycle is timed alongside the request, since it starts before the stop is over.
    fork
      request(SLAVE_ADDR, ack);
      begin
        // wait for the cycle to end
        for (n = 0; core_awake !== 1'b1 && n < 5000; n++) #4;
        for (n = 0; core_awake === 1'b1 && n < 1000; n++) #4;
      end
    join
    chk1(ack, 1'b0);
    chk1(meas_done, 1'b1);
    e = WK + CV[hr] + CV[tr];
    chk1(n >= e && n <= e + 4, 1'b1);
    #200;
    fetch(4, ack, f);
    x = {STAT_VALID, exp_scale(hs, hr), exp_scale(ts, tr), 2'b00};
    chk32(f & 32'hffff_fffc, x);
  endtask
  task automatic t_refetch(input logic [13:0] h, input logic [13:0] t);
    logic ack;
    logic [31:0] f;
    fetch(2, ack, f);
    chk32(f, {16'h0, STAT_STALE, h});
    fetch(3, ack, f);
    chk32(f, {8'h0, STAT_STALE, h, t[13:6]});
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    #200;
    t_early_fetch();
    t_foreign();
    t_cancel();
    t_measure(0, 2, 14'h2a5b, 14'h1c3d);
    t_measure(3, 1, 14'h35a7, 14'h0e69);
    t_refetch(14'h35a7, exp_scale(14'h0e69, 1));
    results();
  end
  initial begin
    #380_000;
    failures++;
    results();
  end
endmodule // hti_readout_tb_top
bind hti_readout hti_readout_checker #(.WAKE_CYCLES(WAKE_CYCLES),
  .CONV14_CYCLES(CONV14_CYCLES)) u_hti_readout_checker (.ref_clk(ref_clk), .rst(rst),
  .link_clk(link_clk), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .core_awake(core_awake), .meas_done(meas_done));
`default_nettype wire
